// ### rtl/ist_pkg.sv
// shared constants and types for the i2c slave data and time-out block
package ist_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_OWN = 8'h04;
  localparam logic [7:0] OFS_CTL0 = 8'h08;
  localparam logic [7:0] OFS_CTL1 = 8'h0c;
  localparam logic [7:0] OFS_TOC = 8'h10;

  // serial_control_zero fields
  localparam int C0_EN = 0;
  // serial_control_one fields
  localparam int C1_ACK_RECEIVED = 0;
  localparam int C1_READ_REQ = 2;
  localparam int C1_ACK_TO_SEND = 3;
  localparam int C1_TX_DIR = 4;
  localparam int C1_BUSY = 5;
  localparam int C1_ADDR_MATCH = 6;
  // timeout_control_register fields
  localparam int TOC_EN = 7;
  localparam int TOC_FLAG = 6;
  localparam int TOC_PER_HI = 5;

  // reset values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [6:0] RST_OWN = 7'h00;
  localparam logic RST_BIT = 1'b0;
  localparam logic [5:0] RST_PER = 6'h00;

  // timing: system clock, sub clock and its divide-by-32 time-out tick
  localparam longint CLK_HZ = 200_000_000;
  localparam longint SUB_HZ = 32_768;
  localparam longint SUB_DIV_COUNT = 32;
  localparam longint SUB_CYCLES = CLK_HZ / SUB_HZ;
  localparam int TICK_CYCLES_DOC = int'(SUB_CYCLES * SUB_DIV_COUNT);

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_HOLD = 4'h3,
    ST_RX = 4'h4,
    ST_RX_ACK = 4'h5,
    ST_TX = 4'h6,
    ST_TX_ACK = 4'h7,
    ST_WAIT_STOP = 4'h8
  } ist_state_t;

endpackage

// ### rtl/ist_i2c_slave.sv
// i2c slave data phase, clock stretching and bus time-out with axi4-lite registers
//
// Overview of operation
// - bytes are eight bits, msb first
// - receiver acknowledges each byte with a low
// - on master nack, release sda for stop
// - received bytes land in data buffer
// - receive mode: ack_to_send driven on ninth clock
// - transmit mode: record master ack, nack ends
// - stretch scl until data buffer access
// - counter starts on match, cleared each scl fall
// - interval elapsed before scl fall means time-out
// - stop condition halts the time-out counter
// - overflow: halt, clear enable, set flag
// - time-out requests the shared interrupt
// - time-out resets bus logic and control one
// - flag set by hardware, cleared by software
// - interval is (period+1) times 32 sub clocks
// - enable bit7, flag bit6, period bits 5-0
// - seven-bit address plus read/write bit, match flagged
// - ack_to_send zero makes device acknowledge
// - software sets transmit_direction from read request
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

module ist_i2c_slave
  import ist_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DOC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq_req
);

  localparam int DIV_W = $clog2(TICK_CYCLES + 1);

  function automatic logic ist_hit(input logic [7:0] addr, input logic [7:0] ofs);
    ist_hit = (addr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic ist_mapped(input logic [7:0] addr);
    ist_mapped = ist_hit(addr, OFS_DATA) | ist_hit(addr, OFS_OWN) | ist_hit(addr, OFS_CTL0)
      | ist_hit(addr, OFS_CTL1) | ist_hit(addr, OFS_TOC);
  endfunction

  ist_state_t state_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] shift_ff;
  logic sda_drv_ff, scl_hold_ff;
  logic scl_q_ff, sda_q_ff;
  logic [7:0] data_ff;
  logic [6:0] own_ff;
  logic ctl0_en_ff;
  logic ack_to_send_ff, transmit_direction_ff, address_match_flag_ff;
  logic master_read_request_ff, ack_received_ff;
  logic toc_en_ff, toc_flag_ff;
  logic [5:0] toc_per_ff;
  logic to_run_ff;
  logic [5:0] to_cnt_ff;
  logic [DIV_W-1:0] div_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic irq_ff;

  // pins are synchronous to clock; one register stage gives the edge history
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_i & ~scl_q_ff;
  assign scl_fall = ~scl_i & scl_q_ff;
  assign start_det = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign stop_det = scl_i & scl_q_ff & ~sda_q_ff & sda_i;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  // ---------------- axi4-lite slave ----------------
  // write is taken only when address and data are both offered
  logic wr_go, rd_go;
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign rd_go = s_axi_arvalid & ~rvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  logic wr_lane, wr_data, wr_own, wr_ctl0, wr_ctl1, wr_toc, rd_data, sw_touch;
  assign wr_lane = wr_go & s_axi_wstrb[0];
  assign wr_data = wr_lane & ist_hit(s_axi_awaddr, OFS_DATA);
  assign wr_own = wr_lane & ist_hit(s_axi_awaddr, OFS_OWN);
  assign wr_ctl0 = wr_lane & ist_hit(s_axi_awaddr, OFS_CTL0);
  assign wr_ctl1 = wr_lane & ist_hit(s_axi_awaddr, OFS_CTL1);
  assign wr_toc = wr_lane & ist_hit(s_axi_awaddr, OFS_TOC);
  assign rd_data = rd_go & ist_hit(s_axi_araddr, OFS_DATA);
  assign sw_touch = wr_data | rd_data;

  logic [7:0] ctl1_view, toc_view, rd_mux;
  assign ctl1_view = {1'b0, address_match_flag_ff, state_ff != ST_IDLE, transmit_direction_ff,
    ack_to_send_ff, master_read_request_ff, 1'b0, ack_received_ff};
  assign toc_view = {toc_en_ff, toc_flag_ff, toc_per_ff};

  always_comb begin
    if (ist_hit(s_axi_araddr, OFS_DATA)) begin
      rd_mux = data_ff;
    end else if (ist_hit(s_axi_araddr, OFS_OWN)) begin
      rd_mux = {1'b0, own_ff};
    end else if (ist_hit(s_axi_araddr, OFS_CTL0)) begin
      rd_mux = {7'h00, ctl0_en_ff};
    end else if (ist_hit(s_axi_araddr, OFS_CTL1)) begin
      rd_mux = ctl1_view;
    end else if (ist_hit(s_axi_araddr, OFS_TOC)) begin
      rd_mux = toc_view;
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= ist_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= ist_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= {24'h00_0000, rd_mux};
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ---------------- byte engine ----------------
  logic fsm_go, byte_done, addr_done, addr_match, match_evt, rx_store, to_event;
  logic [7:0] tx_byte;
  assign fsm_go = ctl0_en_ff & ~to_event & ~start_det & ~stop_det;
  assign byte_done = scl_fall & (bitcnt_ff == BYTE_BITS);
  assign addr_done = fsm_go & (state_ff == ST_ADDR) & byte_done;
  assign addr_match = shift_ff[7:1] == own_ff;
  assign match_evt = addr_done & addr_match;
  assign rx_store = fsm_go & (state_ff == ST_RX) & byte_done;
  assign tx_byte = wr_data ? s_axi_wdata[7:0] : data_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      sda_drv_ff <= 1'b0;
      scl_hold_ff <= 1'b0;
      address_match_flag_ff <= RST_BIT;
      master_read_request_ff <= RST_BIT;
      ack_received_ff <= RST_BIT;
    end else if (!ctl0_en_ff || to_event) begin
      state_ff <= ST_IDLE;
      sda_drv_ff <= 1'b0;
      scl_hold_ff <= 1'b0;
      if (to_event) begin
        address_match_flag_ff <= RST_BIT;
        master_read_request_ff <= RST_BIT;
        ack_received_ff <= RST_BIT;
      end
    end else if (start_det) begin
      state_ff <= ST_ADDR;
      bitcnt_ff <= 4'h0;
      sda_drv_ff <= 1'b0;
      scl_hold_ff <= 1'b0;
      address_match_flag_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
      sda_drv_ff <= 1'b0;
      scl_hold_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_i};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end else if (byte_done) begin
            if (addr_match) begin
              address_match_flag_ff <= 1'b1;
              master_read_request_ff <= shift_ff[0];
              sda_drv_ff <= 1'b1;
              state_ff <= ST_ADDR_ACK;
            end else begin
              state_ff <= ST_WAIT_STOP;
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          if (scl_fall) begin
            sda_drv_ff <= 1'b0;
            scl_hold_ff <= 1'b1;
            state_ff <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (sw_touch) begin
            scl_hold_ff <= 1'b0;
            bitcnt_ff <= 4'h0;
            if (transmit_direction_ff) begin
              shift_ff <= tx_byte;
              sda_drv_ff <= ~tx_byte[7];
              state_ff <= ST_TX;
            end else begin
              sda_drv_ff <= 1'b0;
              state_ff <= ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_i};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end else if (byte_done) begin
            sda_drv_ff <= ~ack_to_send_ff;
            state_ff <= ST_RX_ACK;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end else if (byte_done) begin
            sda_drv_ff <= 1'b0;
            state_ff <= ST_TX_ACK;
          end else if (scl_fall) begin
            sda_drv_ff <= ~shift_ff[6];
            shift_ff <= {shift_ff[6:0], 1'b0};
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_received_ff <= sda_i;
          end else if (scl_fall) begin
            if (!ack_received_ff) begin
              scl_hold_ff <= 1'b1;
              state_ff <= ST_HOLD;
            end else begin
              state_ff <= ST_WAIT_STOP;
            end
          end
        end
        default: begin
          sda_drv_ff <= 1'b0;
        end
      endcase
    end
  end

  // open-drain pins: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_hold_ff;
  assign sda_oe = sda_drv_ff;

  // ---------------- software registers ----------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      data_ff <= RST_DATA;
    end else if (rx_store) begin
      data_ff <= shift_ff;
    end else if (wr_data) begin
      data_ff <= s_axi_wdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      own_ff <= RST_OWN;
      ctl0_en_ff <= RST_BIT;
    end else begin
      if (wr_own) begin
        own_ff <= s_axi_wdata[6:0];
      end
      if (wr_ctl0) begin
        ctl0_en_ff <= s_axi_wdata[C0_EN];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_to_send_ff <= RST_BIT;
      transmit_direction_ff <= RST_BIT;
    end else if (to_event) begin
      ack_to_send_ff <= RST_BIT;
      transmit_direction_ff <= RST_BIT;
    end else if (wr_ctl1) begin
      ack_to_send_ff <= s_axi_wdata[C1_ACK_TO_SEND];
      transmit_direction_ff <= s_axi_wdata[C1_TX_DIR];
    end
  end

  // hardware events win over software writes to the same bits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      toc_en_ff <= RST_BIT;
      toc_flag_ff <= RST_BIT;
      toc_per_ff <= RST_PER;
    end else begin
      if (wr_toc) begin
        toc_per_ff <= s_axi_wdata[TOC_PER_HI:0];
      end
      if (to_event) begin
        toc_en_ff <= 1'b0;
      end else if (wr_toc) begin
        toc_en_ff <= s_axi_wdata[TOC_EN];
      end
      if (to_event) begin
        toc_flag_ff <= 1'b1;
      end else if (wr_toc && !s_axi_wdata[TOC_FLAG]) begin
        toc_flag_ff <= 1'b0;
      end
    end
  end

  // ---------------- time-out counter ----------------
  // divider restarts with each scl fall so every interval is full length
  logic to_clr, to_tick;
  assign to_clr = scl_fall | match_evt;
  assign to_tick = div_ff == DIV_W'(TICK_CYCLES - 1);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= '0;
    end else if (to_clr || to_tick || !to_run_ff) begin
      div_ff <= '0;
    end else if (toc_en_ff) begin
      div_ff <= div_ff + DIV_W'(1);
    end
  end

  assign to_event = to_run_ff & toc_en_ff & to_tick & ~to_clr
    & (to_cnt_ff == toc_per_ff);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      to_run_ff <= 1'b0;
      to_cnt_ff <= 6'h00;
    end else begin
      if (stop_det || to_event) begin
        to_run_ff <= 1'b0;
      end else if (match_evt) begin
        to_run_ff <= 1'b1;
      end
      if (to_clr || to_event) begin
        to_cnt_ff <= 6'h00;
      end else if (to_run_ff && toc_en_ff && to_tick) begin
        to_cnt_ff <= to_cnt_ff + 6'h01;
      end
    end
  end

  // one request line shared by match, byte completion and time-out
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= match_evt | to_event | (fsm_go & scl_fall
        & ((state_ff == ST_RX_ACK) | (state_ff == ST_TX_ACK)));
    end
  end
  assign irq_req = irq_ff;

  // ---------------- assertions ----------------
  a_to_sets_flag: assert property (@(posedge clock) disable iff (!rst_b)
    to_event |=> toc_flag_ff && !toc_en_ff && !to_run_ff)
    else $error("time-out did not set flag and clear enable");

  a_to_resets_ctl1: assert property (@(posedge clock) disable iff (!rst_b)
    to_event |=> !address_match_flag_ff && !transmit_direction_ff && !ack_to_send_ff
      && state_ff == ST_IDLE && !scl_oe)
    else $error("time-out left control one or bus state set");

  a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_b)
    toc_flag_ff && !wr_toc |=> toc_flag_ff)
    else $error("time-out flag dropped without software");

  a_stop_halts: assert property (@(posedge clock) disable iff (!rst_b)
    stop_det |=> !to_run_ff ##1 !to_run_ff || $past(match_evt))
    else $error("time-out counter still running after stop");

  a_fall_clears: assert property (@(posedge clock) disable iff (!rst_b)
    scl_fall |=> to_cnt_ff == 6'h00 && div_ff == '0)
    else $error("scl fall did not clear time-out count");

  a_frozen_off: assert property (@(posedge clock) disable iff (!rst_b)
    !toc_en_ff && !to_clr |=> $stable(to_cnt_ff) && !to_event)
    else $error("time-out counter moved while disabled");

  a_hold_scl: assert property (@(posedge clock) disable iff (!rst_b)
    state_ff == ST_HOLD && !sw_touch && fsm_go |=> scl_oe && state_ff == ST_HOLD)
    else $error("scl released without data buffer access");

  a_rx_ack_level: assert property (@(posedge clock) disable iff (!rst_b)
    rx_store |=> sda_oe == !$past(ack_to_send_ff) && data_ff == $past(shift_ff))
    else $error("receive acknowledge or stored byte wrong");

  a_nack_release: assert property (@(posedge clock) disable iff (!rst_b)
    fsm_go && state_ff == ST_TX_ACK && scl_fall && ack_received_ff
    |=> state_ff == ST_WAIT_STOP && !sda_oe [*2])
    else $error("sda not released after master nack");

  a_irq_match: assert property (@(posedge clock) disable iff (!rst_b)
    match_evt || to_event |=> irq_req ##1 !irq_req || $past(to_event) || $past(scl_fall))
    else $error("interrupt request missing for match or time-out");

endmodule

// ### testbench/ist_i2c_master.sv
// behavioural i2c bus master standing on the far side of the slave
`timescale 1ns/1ps

module ist_i2c_master #(
  parameter int HALF = 10
) (
  input wire logic clock,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_pull,
  output logic sda_pull
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge clock);
  endtask

  // the slave may stretch; the bench watchdog cuts a wait that never ends
  task automatic scl_up();
    scl_pull <= 1'b0;
    do @(posedge clock); while (scl_line !== 1'b1);
  endtask

  // sda moves only while scl is low, two cycles clear of the fall
  task automatic clk_bit(input logic b, output logic r);
    sda_pull <= !b;
    hw(HALF);
    scl_up();
    hw(HALF);
    r = sda_line;
    scl_pull <= 1'b1;
    hw(2);
  endtask

  task automatic start();
    sda_pull <= 1'b0;
    scl_up();
    hw(HALF);
    sda_pull <= 1'b1;
    hw(HALF);
    scl_pull <= 1'b1;
    hw(2);
  endtask

  task automatic stop();
    sda_pull <= 1'b1;
    hw(HALF);
    scl_up();
    hw(HALF);
    sda_pull <= 1'b0;
    hw(HALF);
  endtask

  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, ack);
  endtask

  task automatic byte_rd(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(nack, r);
  endtask
endmodule

// ### testbench/i2c_slave_data_timeout_tb_top.sv
// self-checking bench for the i2c slave data phase and bus time-out
`timescale 1ns/1ps

module i2c_slave_data_timeout_tb_top
  import ist_pkg::*;
();
  localparam int TICK = 20;
  localparam int LIMIT = 40000;
  localparam logic [6:0] ADDR = 7'h2a;
  logic clock = 1'b0;
  logic rst_b;
  logic [7:0] s_axi_awaddr;
  logic [2:0] s_axi_awprot;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic [2:0] s_axi_arprot;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic scl_oe;
  logic sda_oe;
  logic irq_req;
  logic scl_pull;
  logic sda_pull;
  wire logic scl_i;
  wire logic sda_i;
  int err_count = 0;
  int num_checks = 0;
  int irq_n = 0;
  int cyc = 0;
  int rxq[$];

  // both wires are open drain with a pull-up
  assign scl_i = !(scl_pull || scl_oe);
  assign sda_i = !(sda_pull || sda_oe);

  ist_i2c_slave #(.TICK_CYCLES(TICK)) ist_i2c_slave_i (
    .clock, .rst_b, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .scl_i, .scl_o(), .scl_oe, .sda_i, .sda_o(), .sda_oe, .irq_req);

  ist_i2c_master ist_i2c_master_i (
    .clock, .scl_line(scl_i), .sda_line(sda_i), .scl_pull, .sda_pull);

  always #2.5 clock = ~clock;

  always @(posedge clock) begin
    if (irq_req === 1'b1) irq_n <= irq_n + 1;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  // a request holds until the rising edge that takes it; the answer is taken at its own edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge clock);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clock);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, e, d);
    chk({n, " resp"}, 32'(RESP_OKAY), 32'(r));
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic ak;
    logic [7:0] b;
    logic [7:0] g;
    int n0;
    int t;
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h1;
    void'($urandom(32'h371b));
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    rd_chk("toc reset", OFS_TOC, 32'h00000000);
    rd_chk("ctl1 reset", OFS_CTL1, 32'h00000000);
    rd(8'h14, d, r);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    wr(8'h14, 8'h5a, r);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
    wr(OFS_TOC, 8'hff, r);
    chk("toc bresp", 32'(RESP_OKAY), 32'(r));
    rd_chk("toc flag write", OFS_TOC, 32'h000000bf);
    wr(OFS_TOC, 8'h00, r);
    $display("test registers finished");

    wr(OFS_OWN, {1'b0, ADDR}, r);
    wr(OFS_CTL0, 8'h01, r);
    n0 = irq_n;
    ist_i2c_master_i.start();
    ist_i2c_master_i.byte_wr({ADDR, 1'b0}, ak);
    chk("address ack", 32'h0, 32'(ak));
    chk("match irq", n0 + 1, irq_n);
    rd_chk("ctl1 match", OFS_CTL1, 32'h00000060);
    repeat (100) @(posedge clock);
    chk("stretch", 32'h1, 32'(scl_oe));
    chk("disabled timeout", n0 + 1, irq_n);
    rd(OFS_DATA, d, r);
    b = 8'($urandom);
    rxq.push_back(b);
    ist_i2c_master_i.byte_wr(b, ak);
    chk("data ack", 32'h0, 32'(ak));
    // the pulse from the ninth fall is counted at the edge the master returns on, and is seen one edge later
    @(posedge clock);
    chk("byte irq", n0 + 2, irq_n);
    rd_chk("rx byte", OFS_DATA, rxq.pop_front());
    wr(OFS_CTL1, 8'h08, r);
    b = 8'($urandom);
    rxq.push_back(b);
    ist_i2c_master_i.byte_wr(b, ak);
    chk("nack sent", 32'h1, 32'(ak));
    wr(OFS_CTL1, 8'h00, r);
    rd_chk("rx byte 2", OFS_DATA, rxq.pop_front());
    ist_i2c_master_i.stop();
    $display("test receive finished");

    wr(OFS_TOC, 8'h87, r);
    ist_i2c_master_i.start();
    ist_i2c_master_i.byte_wr({ADDR, 1'b1}, ak);
    chk("read address ack", 32'h0, 32'(ak));
    rd_chk("ctl1 read req", OFS_CTL1, 32'h00000064);
    wr(OFS_CTL1, 8'h10, r);
    b = 8'($urandom);
    wr(OFS_DATA, b, r);
    ist_i2c_master_i.byte_rd(1'b0, g);
    chk("tx byte", 32'(b), 32'(g));
    rd(OFS_CTL1, d, r);
    chk("ack seen", 32'h0, 32'(d[C1_ACK_RECEIVED]));
    b = 8'($urandom);
    wr(OFS_DATA, b, r);
    ist_i2c_master_i.byte_rd(1'b1, g);
    chk("tx byte 2", 32'(b), 32'(g));
    repeat (4) @(posedge clock);
    chk("sda freed", 32'h0, 32'(sda_oe));
    rd(OFS_CTL1, d, r);
    chk("nack seen", 32'h1, 32'(d[C1_ACK_RECEIVED]));
    ist_i2c_master_i.stop();
    n0 = irq_n;
    repeat (400) @(posedge clock);
    chk("halted after stop", n0, irq_n);
    rd_chk("toc kept", OFS_TOC, 32'h00000087);
    $display("test transmit finished");

    wr(OFS_TOC, 8'h82, r);
    ist_i2c_master_i.start();
    ist_i2c_master_i.byte_wr({ADDR, 1'b0}, ak);
    n0 = irq_n;
    t = 0;
    while (irq_n == n0 && t < 1000) begin
      @(posedge clock);
      t++;
    end
    // time is taken from two cycles after the last scl fall
    chk("timeout time", 32'h1, 32'(t >= 3 * TICK - 10 && t <= 3 * TICK + 2));
    chk("pins freed", 32'h0, 32'({scl_oe, sda_oe}));
    rd_chk("toc timeout", OFS_TOC, 32'h00000042);
    rd_chk("ctl1 timeout", OFS_CTL1, 32'h00000000);
    rd_chk("own kept", OFS_OWN, 32'({1'b0, ADDR}));
    rd_chk("ctl0 kept", OFS_CTL0, 32'h00000001);
    wr(OFS_TOC, 8'h00, r);
    rd_chk("flag cleared", OFS_TOC, 32'h00000000);
    ist_i2c_master_i.stop();
    $display("test timeout finished");
    report_and_stop();
  end
endmodule
